// *** logic/ecs_pkg.sv ***
package ecs_pkg;
	// Clock and timing
	localparam int CLK_PERIOD_NS   = 8;
	localparam int NS_PER_US       = 1000;
	localparam int US_CYCLES_DEF   = NS_PER_US / CLK_PERIOD_NS;
	localparam int HOLD_MAX_US     = 24000;
	localparam int NUM_OUT         = 2;
	localparam int NUM_THR_DEF     = 8;
	localparam int DUR_W           = 15;
	localparam int CNT_W           = 4;
	localparam int ADDR_W          = 12;

	// Register map, byte addresses
	localparam logic [11:0] ADDR_GLOBAL   = 12'h000;
	localparam logic [11:0] ADDR_STATUS   = 12'h004;
	localparam logic [3:0]  PAGE_OUT0     = 4'h1;
	localparam logic [3:0]  PAGE_OUT1     = 4'h2;
	localparam logic [7:0]  OFF_CTRL      = 8'h00;
	localparam logic [7:0]  OFF_CFG       = 8'h04;
	localparam logic [2:0]  OFF_THR_BLK   = 3'h1;
	localparam logic [2:0]  OFF_CAM_BLK   = 3'h2;

	// Field positions
	localparam int GLB_SYNC_MODE   = 0;
	localparam int CTRL_SET        = 0;
	localparam int CTRL_FLOAT      = 1;
	localparam int CTRL_AUTO       = 2;
	localparam int CTRL_BLK_FWD    = 3;
	localparam int CTRL_BLK_REV    = 4;
	localparam int CFG_BASE_LSB    = 0;
	localparam int CFG_CNT_LSB     = 8;
	localparam int CAM_STATE       = 0;
	localparam int CAM_DUR_LSB     = 16;
	localparam int STS_LEVEL_LSB   = 0;
	localparam int STS_DRIVE_LSB   = 2;
	localparam int STS_CAM_LSB     = 4;
	localparam int STS_HOLD_LSB    = 6;

	// Compared quantity
	localparam logic [1:0] BASE_COUNTER = 2'h0;
	localparam logic [1:0] BASE_FREQ    = 2'h2;

	// AHB-Lite encodings
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [2:0] HSIZE_WORD    = 3'h2;
endpackage

// *** logic/ecs_cam_track.sv ***
`timescale 1ns/1ps
module ecs_cam_track #(
	parameter int NUM_THR   = ecs_pkg::NUM_THR_DEF,
	parameter int US_CYCLES = ecs_pkg::US_CYCLES_DEF
) (
	input  wire logic                         clk,
	input  wire logic                         sys_rst,
	input  wire logic                         autoEnable,
	input  wire logic [1:0]                   baseSel,
	input  wire logic [ecs_pkg::CNT_W-1:0]    activeEventCount,
	input  wire logic                         blockForwardEvents,
	input  wire logic                         blockReverseEvents,
	input  wire logic [31:0]                  thresholds [NUM_THR],
	input  wire logic [NUM_THR-1:0]           camStates,
	input  wire logic [ecs_pkg::DUR_W-1:0]    camDurations [NUM_THR],
	input  wire logic [31:0]                  counterValue,
	input  wire logic                         counterStep,
	input  wire logic                         counterForward,
	input  wire logic                         counterPreset,
	input  wire logic [31:0]                  freqValue,
	input  wire logic                         freqStep,
	output logic                              camLevel,
	output logic                              holdActive
);
	localparam int HOLD_W = $clog2(ecs_pkg::HOLD_MAX_US * US_CYCLES + 1);

	initial begin
		if (NUM_THR < 2 || NUM_THR > 8 || US_CYCLES < 1)
			$error("ecs_cam_track: unsupported parameters");
	end

	logic [31:0]        prevCount;
	logic [HOLD_W-1:0]  holdCount;
	logic               holdBase;
	logic [NUM_THR-1:0] fwdHit;
	logic [NUM_THR-1:0] revHit;
	logic [NUM_THR-1:0] hitVec;
	logic [2:0]         hitIdx;
	logic               hitAny;

	// Clamp event count to what the selected mode allows
	wire logic       counterMode = baseSel == ecs_pkg::BASE_COUNTER;
	wire logic       freqMode    = baseSel == ecs_pkg::BASE_FREQ;
	wire logic [3:0] maxCount    = freqMode ? 4'h2 : 4'(NUM_THR);
	wire logic [3:0] activeN     = (activeEventCount > maxCount) ? maxCount : activeEventCount;
	// Preset loads move the reference but never switch
	wire logic       realStep    = counterStep && !counterPreset;
	wire logic       fwdOk       = counterForward && !blockForwardEvents;
	wire logic       revOk       = !counterForward && !blockReverseEvents;
	wire logic       blockedStep = realStep && !fwdOk && !revOk;

	genvar gi;
	generate
		for (gi = 0; gi < NUM_THR; gi++) begin : g_thr
			// Crossing test against the last reference value, only first N thresholds
			assign fwdHit[gi] = (4'(gi) < activeN) &&
				($signed(thresholds[gi]) > $signed(prevCount)) &&
				($signed(thresholds[gi]) <= $signed(counterValue));
			assign revHit[gi] = (4'(gi) < activeN) &&
				($signed(thresholds[gi]) < $signed(prevCount)) &&
				($signed(thresholds[gi]) >= $signed(counterValue));
		end
	endgenerate

	// Direction filter picks which crossings count
	assign hitVec = fwdOk ? fwdHit : (revOk ? revHit : '0);

	always_comb begin
		hitAny = 1'b0;
		hitIdx = 3'h0;
		// Several crossings in one step: highest index wins forward, lowest index wins in reverse
		for (int i = 0; i < NUM_THR; i++) begin
			if (hitVec[i] && (!hitAny || counterForward)) begin
				hitAny = 1'b1;
				hitIdx = 3'(i);
			end
		end
	end

	// Reverse travel swaps the role of the on and off points
	wire logic                     hitLevel = counterForward ? camStates[hitIdx] :
		!camStates[hitIdx];
	wire logic [ecs_pkg::DUR_W-1:0] hitDur  = camDurations[hitIdx];
	wire logic [HOLD_W-1:0]         holdLoad = HOLD_W'(hitDur * US_CYCLES);
	wire logic                      camHit   = autoEnable && counterMode && realStep && hitAny;
	wire logic freqOn  = freqValue >= thresholds[0];
	wire logic freqOff = (activeN == 4'h1) ? (freqValue < thresholds[0]) :
		(freqValue <= thresholds[1]);

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			prevCount <= '0;
		end else if (counterStep) begin
			prevCount <= counterValue;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			camLevel   <= 1'b0;
			holdActive <= 1'b0;
			holdCount  <= '0;
			holdBase   <= 1'b0;
		end else if (!autoEnable) begin
			holdActive <= 1'b0;
		end else if (camHit) begin
			camLevel   <= hitLevel;
			holdActive <= hitDur != '0;
			holdCount  <= holdLoad;
			holdBase   <= holdActive ? holdBase : camLevel;
		end else if (counterMode && blockedStep) begin
			camLevel   <= 1'b0;
			holdActive <= 1'b0;
		end else if (freqMode && freqStep && activeN != 4'h0) begin
			camLevel   <= freqOn ? 1'b1 : (freqOff ? 1'b0 : camLevel);
			holdActive <= 1'b0;
		end else if (holdActive) begin
			holdCount  <= holdCount - HOLD_W'(1);
			if (holdCount == HOLD_W'(1)) begin
				holdActive <= 1'b0;
				camLevel   <= holdBase;
			end
		end
	end

	sequence s_presetOnly;
		counterPreset && !holdActive && !freqMode;
	endsequence

	a_preset_no_switch: assert property (@(posedge clk) disable iff (sys_rst)
		s_presetOnly |=> camLevel == $past(camLevel))
		else $error("Preset load switched the output");

	a_fwd_cam_level: assert property (@(posedge clk) disable iff (sys_rst)
		camHit && counterForward |=> camLevel == $past(camStates[hitIdx]))
		else $error("Forward crossing gave wrong level");

	a_rev_cam_level: assert property (@(posedge clk) disable iff (sys_rst)
		camHit && !counterForward |=> camLevel == !$past(camStates[hitIdx]))
		else $error("Reverse crossing gave wrong level");

	a_freq_switch_on: assert property (@(posedge clk) disable iff (sys_rst)
		autoEnable && freqMode && freqStep && activeN != 4'h0 && freqOn |=> camLevel)
		else $error("Frequency above first threshold not on");
endmodule

// *** logic/ecs_cam_switch.sv ***
// Behaviour
// - Float off: drive high or low per set value; float on: pin released.
// - Automatic switching enabled: direct set value and float request ignored.
// - Direct value applied on frame arrival or on local sync tick, per mode.
// - Each output has up to eight programmable thresholds.
// - Reference selector: 0 compares counter value, 2 compares frequency value.
// - Counter mode levels free; frequency mode threshold one on, two off.
// - Counter mode hold time up to 24000 us; zero holds until next.
// - Event count 1 to 8 for counter, 1 or 2 for frequency.
// - Two direction block flags select forward, reverse or both directions.
// - The two outputs are independent cam tracks.
// - Cams activatable separately; thresholds rewritable every cycle. Code activates only the first N cams, N the event count.
// - Position cam: one threshold switches on, another switches off.
// - On below off: output true between the two points only.
// - On above off: cam behaviour inverted.
// - Switch-on point is on threshold forward, off threshold in reverse.
// - Time cam: reaching its threshold applies its level for its duration.
// - Time cam with zero duration keeps its level until the next cam.
// - Enabling at standstill uses last known level, false if none.
// - Only counting pulses switch; preset loads landing on thresholds do not.
//
// The AHB-Lite register port and the register addresses were left to the implementer.
`timescale 1ns/1ps
module ecs_cam_switch #(
	parameter int NUM_THR   = ecs_pkg::NUM_THR_DEF,
	parameter int US_CYCLES = ecs_pkg::US_CYCLES_DEF
) (
	input  wire logic        clk,
	input  wire logic        sys_rst,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic [31:0]      hrdata,
	output logic             hresp,
	input  wire logic [31:0] counterValue,
	input  wire logic        counterStep,
	input  wire logic        counterForward,
	input  wire logic        counterPreset,
	input  wire logic [31:0] freqValue,
	input  wire logic        freqStep,
	input  wire logic        localSyncClock,
	output logic [1:0]       outLevel,
	output logic [1:0]       outEnable
);
	localparam int NO = ecs_pkg::NUM_OUT;

	initial begin
		if (NUM_THR < 2 || NUM_THR > 8 || US_CYCLES < 1)
			$error("ecs_cam_switch: unsupported parameters");
	end

	// Bus state
	logic                       wrPend;
	logic                       rdPend;
	logic [ecs_pkg::ADDR_W-1:0] addrReg;
	logic                       syncMode;
	logic [2:0]                 syncPipe;
	logic                       syncLevel;

	// Per output registers
	logic [4:0]                 outCtrl    [NO];
	logic [1:0]                 baseSel    [NO];
	logic [ecs_pkg::CNT_W-1:0]  eventCount [NO];
	logic [31:0]                thr        [NO][NUM_THR];
	logic [NUM_THR-1:0]         camState   [NO];
	logic [ecs_pkg::DUR_W-1:0]  camDur     [NO][NUM_THR];
	logic [NO-1:0]              appliedSet;
	logic [NO-1:0]              appliedFloat;
	logic [NO-1:0]              camLevel;
	logic [NO-1:0]              holdActive;
	logic [31:0]                readMux;

	// Address phase decode
	wire logic       addrTaken = hsel && hready && htrans == ecs_pkg::HTRANS_NONSEQ;
	wire logic       doWrite   = wrPend;
	wire logic [3:0] page      = addrReg[11:8];
	wire logic [7:0] offs      = addrReg[7:0];
	wire logic       pageOut   = page == ecs_pkg::PAGE_OUT0 || page == ecs_pkg::PAGE_OUT1;
	wire logic       outSel    = page == ecs_pkg::PAGE_OUT1;
	wire logic [2:0] entry     = offs[4:2];
	wire logic       hitCtrl   = pageOut && offs == ecs_pkg::OFF_CTRL;
	wire logic       hitCfg    = pageOut && offs == ecs_pkg::OFF_CFG;
	wire logic       hitThr    = pageOut && offs[7:5] == ecs_pkg::OFF_THR_BLK &&
		32'(entry) < NUM_THR;
	wire logic       hitCam    = pageOut && offs[7:5] == ecs_pkg::OFF_CAM_BLK &&
		32'(entry) < NUM_THR;
	wire logic       hitGlobal = addrReg == ecs_pkg::ADDR_GLOBAL;
	wire logic       hitStatus = addrReg == ecs_pkg::ADDR_STATUS;

	// Sync tick once second and third stages agree high; a one-clock glitch never counts
	wire logic       syncTick  = syncPipe[1] && syncPipe[2] && !syncLevel;
	// Frame arrival is the write of a control word
	wire logic       frameCtrl = doWrite && hitCtrl;

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			syncPipe  <= '0;
			syncLevel <= 1'b0;
		end else begin
			syncPipe <= {syncPipe[1:0], localSyncClock};
			if (syncPipe[1] == syncPipe[2]) begin
				syncLevel <= syncPipe[2];
			end
		end
	end

	// Bus slave: writes take no wait, reads one wait state
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			wrPend    <= 1'b0;
			rdPend    <= 1'b0;
			addrReg   <= '0;
			hreadyout <= 1'b1;
			hrdata    <= '0;
			hresp     <= 1'b0;
		end else begin
			wrPend <= addrTaken && hwrite;
			rdPend <= addrTaken && !hwrite;
			if (addrTaken) begin
				addrReg <= haddr[ecs_pkg::ADDR_W-1:0];
			end
			hreadyout <= !(addrTaken && !hwrite);
			if (rdPend) begin
				hrdata <= readMux;
			end
		end
	end

	always_comb begin
		readMux = '0;
		if (hitGlobal) begin
			readMux[ecs_pkg::GLB_SYNC_MODE] = syncMode;
		end else if (hitStatus) begin
			readMux[ecs_pkg::STS_LEVEL_LSB +: 2] = outLevel;
			readMux[ecs_pkg::STS_DRIVE_LSB +: 2] = outEnable;
			readMux[ecs_pkg::STS_CAM_LSB +: 2]   = camLevel;
			readMux[ecs_pkg::STS_HOLD_LSB +: 2]  = holdActive;
		end else if (hitCtrl) begin
			readMux[4:0] = outCtrl[outSel];
		end else if (hitCfg) begin
			readMux[ecs_pkg::CFG_BASE_LSB +: 2] = baseSel[outSel];
			readMux[ecs_pkg::CFG_CNT_LSB +: ecs_pkg::CNT_W] = eventCount[outSel];
		end else if (hitThr) begin
			readMux = thr[outSel][entry];
		end else if (hitCam) begin
			readMux[ecs_pkg::CAM_STATE] = camState[outSel][entry];
			readMux[ecs_pkg::CAM_DUR_LSB +: ecs_pkg::DUR_W] = camDur[outSel][entry];
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			syncMode <= 1'b0;
		end else if (doWrite && hitGlobal) begin
			syncMode <= hwdata[ecs_pkg::GLB_SYNC_MODE];
		end
	end

	genvar go;
	generate
		for (go = 0; go < NO; go++) begin : g_out
			wire logic mine = outSel == 1'(go);
			wire logic auto = outCtrl[go][ecs_pkg::CTRL_AUTO];

			always_ff @(posedge clk or posedge sys_rst) begin
				if (sys_rst) begin
					outCtrl[go]    <= '0;
					baseSel[go]    <= ecs_pkg::BASE_COUNTER;
					eventCount[go] <= '0;
				end else begin
					if (doWrite && hitCtrl && mine) begin
						outCtrl[go] <= hwdata[4:0];
					end
					if (doWrite && hitCfg && mine) begin
						baseSel[go]    <= hwdata[ecs_pkg::CFG_BASE_LSB +: 2];
						eventCount[go] <= hwdata[ecs_pkg::CFG_CNT_LSB +: ecs_pkg::CNT_W];
					end
				end
			end

			// Thresholds and cams rewritable at any time, taking effect next update
			always_ff @(posedge clk or posedge sys_rst) begin
				if (sys_rst) begin
					camState[go] <= '0;
					for (int k = 0; k < NUM_THR; k++) begin
						thr[go][k]    <= '0;
						camDur[go][k] <= '0;
					end
				end else if (doWrite && mine && hitThr) begin
					thr[go][entry] <= hwdata;
				end else if (doWrite && mine && hitCam) begin
					camState[go][entry] <= hwdata[ecs_pkg::CAM_STATE];
					camDur[go][entry]   <= hwdata[ecs_pkg::CAM_DUR_LSB +: ecs_pkg::DUR_W];
				end
			end

			// Direct value staged in the control word, applied on the mode's trigger
			always_ff @(posedge clk or posedge sys_rst) begin
				if (sys_rst) begin
					appliedSet[go]   <= 1'b0;
					appliedFloat[go] <= 1'b0;
				end else if (!syncMode && frameCtrl && mine) begin
					appliedSet[go]   <= hwdata[ecs_pkg::CTRL_SET];
					appliedFloat[go] <= hwdata[ecs_pkg::CTRL_FLOAT];
				end else if (syncMode && syncTick) begin
					appliedSet[go]   <= outCtrl[go][ecs_pkg::CTRL_SET];
					appliedFloat[go] <= outCtrl[go][ecs_pkg::CTRL_FLOAT];
				end
			end

			// Pins come straight from these flops
			always_ff @(posedge clk or posedge sys_rst) begin
				if (sys_rst) begin
					outLevel[go]  <= 1'b0;
					outEnable[go] <= 1'b0;
				end else if (auto) begin
					outLevel[go]  <= camLevel[go];
					outEnable[go] <= 1'b1;
				end else begin
					outLevel[go]  <= appliedSet[go] && !appliedFloat[go];
					outEnable[go] <= !appliedFloat[go];
				end
			end

			// Each output owns a complete, separate track
			ecs_cam_track #(
				.NUM_THR   (NUM_THR),
				.US_CYCLES (US_CYCLES)
			) u_track (
				.clk                (clk),
				.sys_rst            (sys_rst),
				.autoEnable         (auto),
				.baseSel            (baseSel[go]),
				.activeEventCount   (eventCount[go]),
				.blockForwardEvents (outCtrl[go][ecs_pkg::CTRL_BLK_FWD]),
				.blockReverseEvents (outCtrl[go][ecs_pkg::CTRL_BLK_REV]),
				.thresholds         (thr[go]),
				.camStates          (camState[go]),
				.camDurations       (camDur[go]),
				.counterValue       (counterValue),
				.counterStep        (counterStep),
				.counterForward     (counterForward),
				.counterPreset      (counterPreset),
				.freqValue          (freqValue),
				.freqStep           (freqStep),
				.camLevel           (camLevel[go]),
				.holdActive         (holdActive[go])
			);

			a_float_release: assert property (@(posedge clk) disable iff (sys_rst)
				!auto && appliedFloat[go] |=> !outEnable[go])
				else $error("Float request did not release output");

			a_drive_level: assert property (@(posedge clk) disable iff (sys_rst)
				!auto && !appliedFloat[go] |=> outEnable[go] &&
				outLevel[go] == $past(appliedSet[go]))
				else $error("Driven level differs from set value");

			a_auto_ignores_direct: assert property (@(posedge clk) disable iff (sys_rst)
				auto |=> outEnable[go] && outLevel[go] == $past(camLevel[go]))
				else $error("Automatic output not following cam level");
		end
	endgenerate

	sequence s_frameWrite0;
		!syncMode && frameCtrl && !outSel;
	endsequence

	sequence s_syncApply;
		syncMode && syncTick;
	endsequence

	a_frame_apply: assert property (@(posedge clk) disable iff (sys_rst)
		s_frameWrite0 |=> appliedSet[0] == $past(hwdata[ecs_pkg::CTRL_SET]))
		else $error("Frame write not applied");

	a_sync_apply: assert property (@(posedge clk) disable iff (sys_rst)
		s_syncApply |=> appliedFloat[1] == $past(outCtrl[1][ecs_pkg::CTRL_FLOAT]))
		else $error("Sync tick did not apply staged value");

	a_sync_hold: assert property (@(posedge clk) disable iff (sys_rst)
		syncMode && !syncTick |=> $stable(appliedSet))
		else $error("Direct value changed without sync tick");

	a_read_wait: assert property (@(posedge clk) disable iff (sys_rst)
		addrTaken && !hwrite |=> !hreadyout ##1 hreadyout)
		else $error("Read wait state wrong");

	a_write_no_wait: assert property (@(posedge clk) disable iff (sys_rst)
		addrTaken && hwrite |=> hreadyout)
		else $error("Write inserted a wait state");

	a_sync_single: assert property (@(posedge clk) disable iff (sys_rst)
		syncTick |=> !syncTick)
		else $error("Sync edge counted twice");

	a_frame_hold: assert property (@(posedge clk) disable iff (sys_rst)
		!syncMode && !frameCtrl |=> $stable(appliedSet))
		else $error("Direct value changed without frame write");
endmodule

// *** tb/ecs_master_model.sv ***
`timescale 1ns/1ps
module ecs_master_model (
	input  wire logic        clk,
	input  wire logic        hready,
	input  wire logic [31:0] hrdata,
	output logic             hsel,
	output logic [31:0]      haddr,
	output logic [1:0]       htrans,
	output logic             hwrite,
	output logic [2:0]       hsize,
	output logic [31:0]      hwdata
);
	initial begin
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = ecs_pkg::HSIZE_WORD;
		hwdata = 32'h0;
	end

	// Single word transfer; address held until hready, then data phase held
	task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d,
			output logic [31:0] q);
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= ecs_pkg::HTRANS_NONSEQ;
		haddr <= a;
		hwrite <= wr;
		do @(posedge clk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= wr ? d : ~hwdata;
		do @(posedge clk); while (hready !== 1'b1);
		q = hrdata;
		// Stale data must not look valid after the phase
		hwdata <= ~d;
	endtask
endmodule

// *** tb/encoder_output_cam_switching_bench.sv ***
`timescale 1ns/1ps
module encoder_output_cam_switching_bench;
	logic        clk;
	logic        sys_rst;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [2:0]  hsize;
	logic [31:0] hwdata;
	logic        hreadyout;
	logic [31:0] hrdata;
	logic        hresp;
	logic [31:0] counterValue = 32'h0;
	logic        counterStep = 1'b0;
	logic        counterForward = 1'b0;
	logic        counterPreset = 1'b0;
	logic [31:0] freqValue = 32'h0;
	logic        freqStep = 1'b0;
	logic        localSyncClock = 1'b0;
	logic [1:0]  outLevel;
	logic [1:0]  outEnable;
	int          err_total = 0;
	int          comparisons = 0;
	int          mThr [8];
	bit          mLv [8];
	int          mCnt;
	bit          mOut;
	bit          mBf;
	int          pos;
	int          a;
	int          b;
	int          k;
	logic [15:0] lfsr = 16'h535A;
	int          fq [5] = '{150, 200, 150, 100, 250};
	bit          fe [5] = '{0, 1, 1, 0, 1};

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	ecs_master_model ecs_master_model_i (.clk(clk), .hready(hreadyout), .hrdata(hrdata),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata));

	ecs_cam_switch #(.NUM_THR(8), .US_CYCLES(1)) ecs_cam_switch_i (.clk(clk),
		.sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hrdata(hrdata), .hresp(hresp), .counterValue(counterValue),
		.counterStep(counterStep), .counterForward(counterForward),
		.counterPreset(counterPreset), .freqValue(freqValue), .freqStep(freqStep),
		.localSyncClock(localSyncClock), .outLevel(outLevel), .outEnable(outEnable));

	function automatic logic [15:0] lfsrNext(logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	function automatic logic [31:0] pg(int n);
		return 32'((n + 1) * 256);
	endfunction

	task automatic tally_and_finish;
		if (err_total == 0 && comparisons > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic chk(logic [31:0] got, logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_total++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wr(logic [31:0] addr, logic [31:0] d);
		logic [31:0] q;
		ecs_master_model_i.xfer(1'b1, addr, d, q);
	endtask

	task automatic rd(logic [31:0] addr, logic [31:0] exp);
		logic [31:0] q;
		ecs_master_model_i.xfer(1'b0, addr, 32'h0, q);
		chk(q, exp);
		chk(hresp, 1'b0);
	endtask

	// Counter update on output 0, model tracks the expected cam level
	task automatic step(int nv, bit pre);
		bit fwd;
		fwd = nv > pos;
		counterValue <= nv;
		counterForward <= fwd;
		counterPreset <= pre;
		counterStep <= 1'b1;
		@(posedge clk);
		counterStep <= 1'b0;
		counterPreset <= 1'b0;
		if (!pre) begin
			if (fwd && mBf)
				mOut = 1'b0;
			else if (fwd) begin
				for (int i = 0; i < mCnt; i++)
					if (pos < mThr[i] && mThr[i] <= nv) mOut = mLv[i];
			end else begin
				for (int i = mCnt - 1; i >= 0; i--)
					if (nv <= mThr[i] && mThr[i] < pos) mOut = !mLv[i];
			end
		end
		pos = nv;
		repeat (3) @(posedge clk);
		chk(outLevel[0], mOut);
	endtask

	task automatic setCam(int i, int th, bit lv);
		mThr[i] = th;
		mLv[i] = lv;
		wr(pg(0) + 32'h20 + 32'(4 * i), th);
		wr(pg(0) + 32'h40 + 32'(4 * i), {31'h0, lv});
	endtask

	task automatic fstep(int f, bit e);
		freqValue <= f;
		freqStep <= 1'b1;
		@(posedge clk);
		freqStep <= 1'b0;
		repeat (3) @(posedge clk);
		chk(outLevel[1], e);
	endtask

	initial begin
		repeat (20000) @(posedge clk);
		err_total++;
		tally_and_finish();
	end

	initial begin
		sys_rst = 1'b1;
		repeat (20) @(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
		chk(outEnable, 2'h0);
		rd(32'h300, 32'h0);
		// Direct drive on both outputs, opposite settings each time
		for (k = 0; k < 4; k++) begin
			wr(pg(0), 32'(k));
			wr(pg(1), 32'(~k & 3));
			repeat (2) @(posedge clk);
			chk({outEnable, outLevel & outEnable}, {k[1], !k[1], !k[0] & k[1],
				k[0] & !k[1]});
			chk(outEnable[0], !k[1]);
		end
		// Sync mode: written value waits for the sync edge
		wr(32'h0, 32'h1);
		wr(pg(0), 32'h1);
		repeat (4) @(posedge clk);
		chk(outEnable[0], 1'b0);
		localSyncClock <= 1'b1;
		repeat (3) @(posedge clk);
		localSyncClock <= 1'b0;
		repeat (4) @(posedge clk);
		chk({outEnable[0], outLevel[0]}, 2'h3);
		wr(32'h0, 32'h0);
		// Position cam, random switch points
		lfsr = lfsrNext(lfsrNext(lfsr));
		a = 10 + int'(lfsr[2:0]);
		b = a + 3 + int'(lfsr[5:4]);
		// Direct value from the sync test still drives output 0 high
		mOut = 1'b1;
		step(a - 3, 1'b1);
		mCnt = 2;
		mOut = 1'b0;
		mBf = 1'b0;
		setCam(0, a, 1'b1);
		setCam(1, b, 1'b0);
		wr(pg(0) + 32'h4, 32'h200);
		rd(pg(0) + 32'h4, 32'h200);
		wr(pg(0), 32'h6);
		repeat (3) @(posedge clk);
		chk({outEnable[0], outLevel[0]}, 2'h2);
		for (k = a - 2; k <= b + 1; k++) step(k, 1'b0);
		for (k = b; k >= a - 2; k--) step(k, 1'b0);
		step(a, 1'b1);
		step(a + 1, 1'b0);
		step(a - 2, 1'b0);
		// Swapped points at runtime invert the cam
		setCam(0, b, 1'b1);
		setCam(1, a, 1'b0);
		for (k = a - 1; k <= b + 1; k++) step(k, 1'b0);
		for (k = b; k >= a - 1; k--) step(k, 1'b0);
		// Forward events blocked force the output low
		wr(pg(0), 32'hC);
		mBf = 1'b1;
		step(b + 1, 1'b0);
		step(a, 1'b0);
		wr(pg(0), 32'h4);
		mBf = 1'b0;
		// Timed cam, five cycles at one cycle per microsecond
		mCnt = 1;
		wr(pg(0) + 32'h4, 32'h100);
		setCam(0, pos + 2, 1'b1);
		wr(pg(0) + 32'h40, 32'h0005_0001);
		step(pos + 2, 1'b0);
		repeat (6) @(posedge clk);
		chk(outLevel[0], 1'b0);
		// Frequency mode on output 1, two thresholds with hysteresis, then one threshold
		wr(pg(1) + 32'h20, 32'd200);
		wr(pg(1) + 32'h24, 32'd100);
		wr(pg(1) + 32'h4, 32'h202);
		wr(pg(1), 32'h4);
		for (k = 0; k < 5; k++) fstep(fq[k], fe[k]);
		wr(pg(1) + 32'h4, 32'h102);
		fstep(150, 1'b0);
		chk(outLevel[0], 1'b0);
		tally_and_finish();
	end
endmodule
